// ==== hw/encfb_pkg.sv ====
// Purpose: Shared constants for the encoder feedback block
// Assumes: 40 MHz system clock, Wishbone register access
// Notes:   Offsets are byte addresses of 32-bit words
package encfb_pkg;
    localparam int unsigned CLK_HZ         = 40000000;
    localparam int unsigned SPEED_WIN_MS   = 100;
    localparam int unsigned SPEED_WIN_CYC  = CLK_HZ / 1000 * SPEED_WIN_MS;
    localparam int unsigned AUTO_WIN_CYC   = 64;
    localparam int unsigned MOVE_STEP_CYC  = 40;
    localparam logic [4:0] OFS_CTRL        = 5'h00;
    localparam logic [4:0] OFS_CPR         = 5'h04;
    localparam logic [4:0] OFS_TARGET      = 5'h08;
    localparam logic [4:0] OFS_ACCURACY    = 5'h0C;
    localparam logic [4:0] OFS_POSITION    = 5'h10;
    localparam logic [4:0] OFS_SPEED       = 5'h14;
    localparam logic [4:0] OFS_STATUS      = 5'h18;
    localparam logic [4:0] OFS_KGAIN       = 5'h1C;
    localparam int CTRL_MODE_LO  = 0;
    localparam int CTRL_AUTO     = 2;
    localparam int CTRL_MANDIFF  = 3;
    localparam int CTRL_INVREV   = 4;
    localparam int CTRL_GO       = 5;
    localparam logic [31:0] CTRL_RST     = 32'h0000_0000;
    localparam logic [31:0] CPR_RST      = 32'h0000_0400;
    localparam logic [31:0] ACCURACY_RST = 32'h0000_0004;
    localparam logic [31:0] KGAIN_RST    = 32'h0004_0201;
    typedef enum logic [1:0] {
        MODE_SLIP     = 2'b00,
        MODE_DRIVING  = 2'b01,
        MODE_MEDIATED = 2'b10
    } fb_mode_t;
endpackage

// ==== hw/quad_decoder.sv ====
// Purpose: Four-edge quadrature decode of two encoder phases
// Assumes: Phases already synchronous to clk_i
// Notes:   Illegal double transitions are dropped
`timescale 1ns/1ps
`default_nettype none
module quad_decoder
    import encfb_pkg::*;
#(
    parameter int W = 32
) (
    // System
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    // Phases
    input  wire logic         quad_phase_first_i,
    input  wire logic         quad_phase_second_i,
    // Count
    output logic [W-1:0]      count_o,
    output logic              step_o
);
    logic [1:0]   prev;
    logic [1:0]   next_prev;
    logic [W-1:0] next_count;
    logic         next_step;

    always_comb begin
        next_prev  = {quad_phase_first_i, quad_phase_second_i};
        next_count = count_o;
        next_step  = 1'b0;
        // Each of four edges counts, order gives direction [RL13]
        case ({prev, next_prev})
            4'b0001, 4'b0111, 4'b1110, 4'b1000: begin
                next_count = count_o + W'(1);
                next_step  = 1'b1;
            end
            4'b0010, 4'b1011, 4'b1101, 4'b0100: begin
                next_count = count_o - W'(1);
                next_step  = 1'b1;
            end
            default: ;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            prev    <= 2'b11;
            count_o <= '0;
            step_o  <= 1'b0;
        end else begin
            prev    <= next_prev;
            count_o <= next_count;
            step_o  <= next_step;
        end
    end

    quad_inc_a: assert property (@(posedge clk_i) disable iff (rst_i)
        ($past(prev) == 2'b00 && prev == 2'b01) |-> count_o == $past(count_o) + W'(1))
        else $error("quad count missed forward edge"); // [RL13]
endmodule
`default_nettype wire

// ==== hw/rev_conditioner.sv ====
// Purpose: Revolution sensor conditioning with polarity
// Assumes: Pad pulled high outside, input synchronous
// Notes:   Active pulse output is one cycle per active edge
`timescale 1ns/1ps
`default_nettype none
module rev_conditioner (
    // System
    input  wire logic clk_i,
    input  wire logic rst_i,
    // Sensor
    input  wire logic rev_raw_i,
    input  wire logic invert_i,
    // Conditioned
    output logic      active_o,
    output logic      pulse_o
);
    logic next_active;
    logic next_pulse;

    always_comb begin
        // Low means active unless inverted [RL8] [RL10]
        next_active = invert_i ? rev_raw_i : ~rev_raw_i;
        // Every active edge counts; any pulses per turn [RL11]
        next_pulse  = next_active & ~active_o;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            active_o <= 1'b0;
            pulse_o  <= 1'b0;
        end else begin
            active_o <= next_active;
            pulse_o  <= next_pulse;
        end
    end

    rev_pol_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (!invert_i && !rev_raw_i) |=> active_o)
        else $error("low level not seen as active"); // [RL8]
    rev_inv_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (invert_i && rev_raw_i) |=> active_o)
        else $error("inverted high not seen as active"); // [RL10]
endmodule
`default_nettype wire

// ==== hw/encoder_feedback_revsensor.sv ====
// Purpose: Encoder feedback, mediated positioning and revolution sensor
// Assumes: Classic Wishbone slave, inputs synchronous to clk_i
// Notes:   Speed in RPM over a fixed measuring window
//
// Contract
// RL1 - Encoder serves either as primary position sensor or as slip monitor.
// RL2 - In driving mode the position is the encoder count.
// RL3 - In driving mode speed in RPM comes from count rate and counts per turn.
// RL4 - With a DC motor and encoder, speed and target loops use PID with set gains. Only a position-error PID is built, no speed loop.
// RL5 - In mediated mode position and speed are in encoder units, motion in steps. Speed is reported in RPM in every mode.
// RL6 - Mediated mode moves, reads the encoder, corrects until within accuracy.
// RL7 - Encoder type is auto detected when enabled, else taken from manual choice.
// RL8 - A low level on the revolution input is active by default.
// RL9 - The revolution input idles high so a missing sensor is inactive.
// RL10 - An inversion setting makes a high level active.
// RL11 - One or more active pulses per turn are accepted.
// RL12 - Conditioned revolution signal feeds stall detection and homing.
// RL13 - Phases are decoded counting all four edges per cycle with direction.
`timescale 1ns/1ps
`default_nettype none
module encoder_feedback_revsensor
    import encfb_pkg::*;
#(
    parameter int unsigned SPEED_WIN = SPEED_WIN_CYC
) (
    // System
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // Wishbone
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        we_i,
    input  wire logic [4:0]  adr_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic [31:0] dat_i,
    output logic [31:0]      dat_o,
    output logic             ack_o,
    // Encoder
    input  wire logic        quad_phase_first_i,
    input  wire logic        quad_phase_second_i,
    input  wire logic        enc_diff_sense_i,
    // Revolution sensor pad
    input  wire logic        rev_pad_i,
    output logic             rev_pull_oe_o,
    output logic             rev_pull_o,
    // Motion core
    input  wire logic        dc_motor_i,
    output logic             step_o,
    output logic             dir_o,
    output logic signed [15:0] pid_out_o,
    output logic             enc_is_diff_o,
    output logic             stall_rev_o,
    output logic             home_rev_o
);
    logic [31:0] ctrl, cpr, target, accuracy, kgain;
    logic [31:0] next_ctrl, next_cpr, next_target, next_accuracy, next_kgain;
    logic [31:0] enc_count, speed_rpm, next_speed_rpm;
    logic [31:0] win_start, next_win_start, win_cnt, next_win_cnt;
    logic [31:0] next_dat;
    logic        next_ack;
    logic        enc_step, rev_active, rev_pulse;
    fb_mode_t    mode;

    assign mode = fb_mode_t'(ctrl[CTRL_MODE_LO +: 2]);

    quad_decoder #(.W(32)) u_quad (
        .clk_i               (clk_i),
        .rst_i               (rst_i),
        .quad_phase_first_i  (quad_phase_first_i),
        .quad_phase_second_i (quad_phase_second_i),
        .count_o             (enc_count),
        .step_o              (enc_step)
    );

    rev_conditioner u_rev (
        .clk_i     (clk_i),
        .rst_i     (rst_i),
        .rev_raw_i (rev_pad_i),
        .invert_i  (ctrl[CTRL_INVREV]),
        .active_o  (rev_active),
        .pulse_o   (rev_pulse)
    );

    // Mediated iteration machine
    typedef enum logic [1:0] {
        MS_IDLE  = 2'b00,
        MS_PLAN  = 2'b01,
        MS_MOVE  = 2'b10,
        MS_CHECK = 2'b11
    } med_state_t;
    med_state_t  ms, next_ms;
    logic [31:0] steps_left, next_steps_left;
    logic [7:0]  pace, next_pace;
    logic        next_step, next_dir, done, next_done;
    logic [31:0] dev, abs_dev;

    always_comb begin
        dev     = target - enc_count;
        abs_dev = dev[31] ? (~dev + 32'h0000_0001) : dev;
    end

    always_comb begin
        next_ms         = ms;
        next_steps_left = steps_left;
        next_pace       = pace;
        next_step       = 1'b0;
        next_dir        = dir_o;
        next_done       = done;
        case (ms)
            MS_IDLE: begin
                if (mode == MODE_MEDIATED && ctrl[CTRL_GO]) begin
                    next_ms   = MS_PLAN;
                    next_done = 1'b0;
                end
            end
            MS_PLAN: begin
                // Deviation in counts becomes steps, one per count [RL6]
                next_dir        = ~dev[31];
                next_steps_left = abs_dev;
                next_ms         = MS_MOVE;
            end
            MS_MOVE: begin
                // Motion itself runs as steps [RL5]
                if (steps_left == 32'h0000_0000 && pace == 8'(MOVE_STEP_CYC - 1)) begin
                    next_ms = MS_CHECK; // Pace gap lets the last step reach the count
                end else if (pace == 8'(MOVE_STEP_CYC - 1)) begin
                    next_pace       = 8'h00;
                    next_step       = 1'b1;
                    next_steps_left = steps_left - 32'h0000_0001;
                end else begin
                    next_pace = pace + 8'h01;
                end
            end
            MS_CHECK: begin
                // Repeat until within accuracy [RL6]
                if (abs_dev <= accuracy) begin
                    next_ms   = MS_IDLE;
                    next_done = 1'b1;
                end else begin
                    next_ms = MS_PLAN;
                end
            end
            default: next_ms = MS_IDLE;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ms         <= MS_IDLE;
            steps_left <= '0;
            pace       <= '0;
            step_o     <= 1'b0;
            dir_o      <= 1'b0;
            done       <= 1'b0;
        end else begin
            ms         <= next_ms;
            steps_left <= next_steps_left;
            pace       <= next_pace;
            step_o     <= next_step;
            dir_o      <= next_dir;
            done       <= next_done;
        end
    end

    // Speed over a fixed window: rpm = delta * 60 * win_per_s / cpr [RL3]
    logic [31:0] delta, abs_delta;
    logic [63:0] rpm_num;
    always_comb begin
        delta          = enc_count - win_start;
        abs_delta      = delta[31] ? (~delta + 32'h0000_0001) : delta;
        rpm_num        = 64'(abs_delta) * 64'(60 * (CLK_HZ / SPEED_WIN));
        next_win_cnt   = win_cnt + 32'h0000_0001;
        next_win_start = win_start;
        next_speed_rpm = speed_rpm;
        if (win_cnt == 32'(SPEED_WIN - 1)) begin
            next_win_cnt   = '0;
            next_win_start = enc_count;
            next_speed_rpm = (cpr == 32'h0) ? 32'h0 : 32'(rpm_num / 64'(cpr));
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            win_cnt   <= '0;
            win_start <= '0;
            speed_rpm <= '0;
        end else begin
            win_cnt   <= next_win_cnt;
            win_start <= next_win_start;
            speed_rpm <= next_speed_rpm;
        end
    end

    // PID on position error for DC motor loops [RL4]
    logic signed [31:0] err, err_prev, integ, next_err_prev, next_integ;
    logic signed [47:0] pid_sum;
    logic signed [15:0] next_pid;
    always_comb begin
        err           = $signed(dev);
        next_err_prev = err;
        next_integ    = integ + err;
        pid_sum       = 48'(err) * $signed({1'b0, kgain[7:0]})
                      + 48'(integ) * $signed({1'b0, kgain[15:8]})
                      + 48'(err - err_prev) * $signed({1'b0, kgain[23:16]});
        next_pid      = 16'(pid_sum >>> 8);
        if (!(dc_motor_i && mode == MODE_DRIVING)) begin
            next_integ = '0;
            next_pid   = '0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            err_prev  <= '0;
            integ     <= '0;
            pid_out_o <= '0;
        end else begin
            err_prev  <= next_err_prev;
            integ     <= next_integ;
            pid_out_o <= next_pid;
        end
    end

    // Encoder type detection; sense input held steady a window [RL7]
    logic [6:0] auto_cnt, next_auto_cnt;
    logic       next_is_diff, last_sense, next_last_sense;
    always_comb begin
        next_last_sense = enc_diff_sense_i;
        next_auto_cnt   = auto_cnt;
        next_is_diff    = enc_is_diff_o;
        if (!ctrl[CTRL_AUTO]) begin
            next_is_diff  = ctrl[CTRL_MANDIFF];
            next_auto_cnt = '0;
        end else if (enc_diff_sense_i != last_sense) begin
            next_auto_cnt = '0;
        end else if (auto_cnt == 7'(AUTO_WIN_CYC - 1)) begin
            next_is_diff = enc_diff_sense_i;
        end else begin
            next_auto_cnt = auto_cnt + 7'h01;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            auto_cnt      <= '0;
            last_sense    <= 1'b0;
            enc_is_diff_o <= 1'b0;
        end else begin
            auto_cnt      <= next_auto_cnt;
            last_sense    <= next_last_sense;
            enc_is_diff_o <= next_is_diff;
        end
    end

    // Sensor routing; stall path only when encoder not primary [RL12] [RL1]
    logic next_pull;
    always_comb begin
        next_pull = 1'b1; // Pad idles high [RL9]
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            stall_rev_o   <= 1'b0;
            home_rev_o    <= 1'b0;
            rev_pull_oe_o <= 1'b1;
            rev_pull_o    <= 1'b1;
        end else begin
            stall_rev_o   <= rev_pulse & (mode == MODE_SLIP);
            home_rev_o    <= rev_pulse;
            rev_pull_oe_o <= next_pull;
            rev_pull_o    <= next_pull;
        end
    end

    // Wishbone slave, one wait state then ack
    function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] d, input logic [3:0] s);
        for (int i = 0; i < 4; i++) begin
            merge[i*8 +: 8] = s[i] ? d[i*8 +: 8] : o[i*8 +: 8];
        end
    endfunction

    logic wr;
    always_comb begin
        wr            = cyc_i & stb_i & we_i & ~ack_o;
        next_ack      = cyc_i & stb_i & ~ack_o;
        next_ctrl     = ctrl;
        next_cpr      = cpr;
        next_target   = target;
        next_accuracy = accuracy;
        next_kgain    = kgain;
        if (ms == MS_PLAN) begin
            next_ctrl[CTRL_GO] = 1'b0;
        end
        if (wr) begin
            case (adr_i)
                OFS_CTRL:     next_ctrl     = merge(ctrl, dat_i, sel_i);
                OFS_CPR:      next_cpr      = merge(cpr, dat_i, sel_i);
                OFS_TARGET:   next_target   = merge(target, dat_i, sel_i);
                OFS_ACCURACY: next_accuracy = merge(accuracy, dat_i, sel_i);
                OFS_KGAIN:    next_kgain    = merge(kgain, dat_i, sel_i);
                default: ;
            endcase
        end
        case (adr_i)
            OFS_CTRL:     next_dat = ctrl;
            OFS_CPR:      next_dat = cpr;
            OFS_TARGET:   next_dat = target;
            OFS_ACCURACY: next_dat = accuracy;
            OFS_POSITION: next_dat = enc_count; // Counts, not steps [RL2] [RL5]
            OFS_SPEED:    next_dat = speed_rpm;
            OFS_STATUS:   next_dat = {25'h0, rev_active, enc_is_diff_o, done, ms, mode};
            OFS_KGAIN:    next_dat = kgain;
            default:      next_dat = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl     <= CTRL_RST;
            cpr      <= CPR_RST;
            target   <= '0;
            accuracy <= ACCURACY_RST;
            kgain    <= KGAIN_RST;
            ack_o    <= 1'b0;
            dat_o    <= '0;
        end else begin
            ctrl     <= next_ctrl;
            cpr      <= next_cpr;
            target   <= next_target;
            accuracy <= next_accuracy;
            kgain    <= next_kgain;
            ack_o    <= next_ack;
            dat_o    <= next_dat;
        end
    end

    med_done_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (ms == MS_CHECK && abs_dev <= accuracy) |=> (ms == MS_IDLE && done))
        else $error("mediated move not finished in accuracy"); // [RL6]
    med_retry_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (ms == MS_CHECK && abs_dev > accuracy) |=> ms == MS_PLAN)
        else $error("no corrective move"); // [RL6]
    man_type_a: assert property (@(posedge clk_i) disable iff (rst_i)
        !ctrl[CTRL_AUTO] |=> enc_is_diff_o == $past(ctrl[CTRL_MANDIFF]))
        else $error("manual encoder type ignored"); // [RL7]
    stall_route_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (rev_pulse && mode == MODE_SLIP) |=> stall_rev_o && home_rev_o)
        else $error("revolution pulse not routed"); // [RL12]
    pull_high_a: assert property (@(posedge clk_i) disable iff (rst_i)
        rev_pull_oe_o && rev_pull_o)
        else $error("revolution pad not held high"); // [RL9]
    bus_ack_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (cyc_i && stb_i && !ack_o) |=> ack_o ##1 !ack_o)
        else $error("bus ack not one cycle"); // Bus handshake only, no contract rule
    pid_off_a: assert property (@(posedge clk_i) disable iff (rst_i)
        !dc_motor_i |=> pid_out_o == 16'sh0)
        else $error("pid active without dc motor"); // [RL4]
    step_pace_a: assert property (@(posedge clk_i) disable iff (rst_i)
        step_o |=> !step_o)
        else $error("step pulse too long"); // [RL5]
endmodule
`default_nettype wire

// ==== tb/enc_partner.sv ====
// Purpose: Encoder and revolution sensor model
// Assumes: Requested moves spaced at least 4 cycles apart
// Notes:   Lost steps imitate slip only when the bench loads them
`timescale 1ns/1ps
`default_nettype none
module enc_partner (
    // System
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    // Motion
    input  wire logic       step_i,
    input  wire logic       dir_i,
    input  wire logic       move_i,
    input  wire logic       move_dir_i,
    input  wire logic       lose_load_i,
    input  wire logic [7:0] lose_n_i,
    // Sensor
    input  wire logic       beam_i,
    input  wire logic       wired_i,
    // Pins
    output logic            phase_first_o,
    output logic            phase_second_o,
    output logic            rev_pad_o
);
    logic [1:0] pos;
    logic [1:0] next_pos;
    logic [7:0] lose;
    logic [7:0] next_lose;

    always_comb begin
        next_pos  = pos;
        next_lose = lose_load_i ? lose_n_i : lose;
        if (step_i && lose != 8'h00) begin
            next_lose = lose - 8'h01;
        end else if (step_i) begin
            next_pos = dir_i ? pos + 2'h1 : pos - 2'h1;
        end
        if (move_i) begin
            next_pos = move_dir_i ? pos + 2'h1 : pos - 2'h1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pos  <= 2'h0;
            lose <= 8'h00;
        end else begin
            pos  <= next_pos;
            lose <= next_lose;
        end
    end

    // Gray order, second phase leads when moving up
    assign phase_first_o  = pos[1];
    assign phase_second_o = pos[1] ^ pos[0];
    // Unplugged sensor floats to the pull-up level
    assign rev_pad_o      = wired_i ? beam_i : 1'b1;
endmodule
`default_nettype wire

// ==== tb/test_encoder_feedback_revsensor.sv ====
// Purpose: Self-checking bench for the encoder feedback block
// Assumes: Speed window shortened to 4000 cycles
// Notes:   Bus reads are judged through a queue of notes
`timescale 1ns/1ps
`default_nettype none
module test_encoder_feedback_revsensor
    import encfb_pkg::*;
;
    localparam int unsigned WIN   = 4000;
    localparam int          LIMIT = 40000;
    localparam int          RPM   = (WIN / 100) * 60 * (CLK_HZ / WIN) / 600;
    logic               clk_i = 1'b0;
    logic               rst_i = 1'b1;
    logic               cyc = 1'b0;
    logic               stb = 1'b0;
    logic               we = 1'b0;
    logic [4:0]         adr = 5'h00;
    logic [31:0]        dat = 32'h0;
    logic [31:0]        dat_o;
    logic               ack_o;
    logic               ph1, ph2, pad, pull_oe, pull, step, dir, is_diff, stall, home;
    logic signed [15:0] pid;
    logic               sense = 1'b0, dc = 1'b0, move = 1'b0, move_dir = 1'b0;
    logic               lose_load = 1'b0, beam = 1'b1, wired = 1'b0;
    logic [7:0]         lose_n = 8'h00;
    logic [32:0]        notes[$];
    logic [32:0]        note;
    int                 n_errors = 0, checked = 0, cycles = 0;
    int                 n_home = 0, n_stall = 0, n_step = 0;

    always #12.5 clk_i = ~clk_i;

    encoder_feedback_revsensor #(.SPEED_WIN(WIN)) i_encoder_feedback_revsensor (
        .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
        .sel_i(4'hF), .dat_i(dat), .dat_o(dat_o), .ack_o(ack_o), .quad_phase_first_i(ph1),
        .quad_phase_second_i(ph2), .enc_diff_sense_i(sense), .rev_pad_i(pad),
        .rev_pull_oe_o(pull_oe), .rev_pull_o(pull), .dc_motor_i(dc), .step_o(step),
        .dir_o(dir), .pid_out_o(pid), .enc_is_diff_o(is_diff), .stall_rev_o(stall),
        .home_rev_o(home));

    enc_partner i_enc_partner (
        .clk_i(clk_i), .rst_i(rst_i), .step_i(step), .dir_i(dir), .move_i(move),
        .move_dir_i(move_dir), .lose_load_i(lose_load), .lose_n_i(lose_n), .beam_i(beam),
        .wired_i(wired), .phase_first_o(ph1), .phase_second_o(ph2), .rev_pad_o(pad));

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic complete_run();
        $display("Counts: %0d checks, %0d mismatches", checked, n_errors);
        if (n_errors == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
    endtask

    // Single classic cycle; waits on ack, giving up after 50 cycles
    task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d, input logic c,
                       output logic [31:0] r);
        int t;
        t = 0;
        notes.push_back({c & ~w, d});
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we  <= w;
        adr <= a;
        dat <= w ? d : 32'h0;
        do begin
            @(posedge clk_i);
            t++;
        end while (ack_o !== 1'b1 && t < 50);
        r = dat_o;
        if (t >= 50) begin
            n_errors++;
        end
        cyc <= 1'b0;
        stb <= 1'b0;
        we  <= 1'b0;
    endtask

    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        logic [31:0] r;
        bus(1'b1, a, d, 1'b0, r);
    endtask

    task automatic rd(input logic [4:0] a, input logic [31:0] e);
        logic [31:0] r;
        bus(1'b0, a, e, 1'b1, r);
    endtask

    task automatic mv(input logic up, input int n, input int gap);
        repeat (n) begin
            @(posedge clk_i);
            move     <= 1'b1;
            move_dir <= up;
            @(posedge clk_i);
            move <= 1'b0;
            tick(gap - 2);
        end
        tick(4);
    endtask

    task automatic pulses(input int n, input logic lvl, input int act, input int idle);
        repeat (n) begin
            beam <= lvl;
            tick(act);
            beam <= ~lvl;
            tick(idle);
        end
    endtask

    // Oldest note is popped on each ack and judged only when it flags a checked read
    always @(posedge clk_i) begin
        cycles++;
        n_home  += (home === 1'b1);
        n_stall += (stall === 1'b1);
        n_step  += (step === 1'b1);
        if (ack_o === 1'b1 && notes.size() > 0) begin
            note = notes.pop_front();
            if (note[32]) begin
                check("read data", dat_o, note[31:0]);
            end
        end
        if (cycles == LIMIT) begin
            n_errors++;
            complete_run();
        end
    end

    initial begin
        logic [31:0] r, p0, tgt;
        int          h0, s0, k;
        void'($urandom(99290));
        tick(4);
        rst_i <= 1'b0;
        tick(1);
        check("pull enable", {31'h0, pull_oe}, 32'h1);
        check("pull level", {31'h0, pull}, 32'h1);
        rd(OFS_CTRL, CTRL_RST);
        rd(OFS_CPR, CPR_RST);
        rd(OFS_ACCURACY, ACCURACY_RST);
        rd(OFS_KGAIN, KGAIN_RST);
        wr(OFS_POSITION, 32'h0000_0055);
        rd(OFS_POSITION, 32'h0000_0000);
        bus(1'b0, OFS_STATUS, 32'h0, 1'b0, r);
        check("idle sensor", {31'h0, r[6]}, 32'h0);
        $display("Test registers done");
        wr(OFS_CTRL, 32'h0000_0001);
        k = 1 + $urandom % 40;
        mv(1'b1, k, 5);
        rd(OFS_POSITION, 32'(k));
        mv(1'b0, k + 3, 5);
        rd(OFS_POSITION, 32'hFFFF_FFFD);
        wr(OFS_CPR, 32'd600);
        mv(1'b1, 120, 100);
        bus(1'b0, OFS_SPEED, 32'h0, 1'b0, r);
        check("speed", {31'h0, r >= RPM - 1000 && r <= RPM + 1000}, 32'h1);
        $display("Test driving done");
        bus(1'b0, OFS_POSITION, 32'h0, 1'b0, p0);
        dc <= 1'b1;
        wr(OFS_TARGET, p0 + 32'd100);
        tick(10);
        check("pid drive", {31'h0, pid > 16'sh0000}, 32'h1);
        dc <= 1'b0;
        tick(3);
        check("pid idle", {16'h0, pid}, 32'h0);
        wr(OFS_CTRL, 32'h0000_0009);
        tick(4);
        check("manual type", {31'h0, is_diff}, 32'h1);
        wr(OFS_CTRL, 32'h0000_0005);
        tick(80);
        check("auto single", {31'h0, is_diff}, 32'h0);
        sense <= 1'b1;
        tick(80);
        check("auto diff", {31'h0, is_diff}, 32'h1);
        $display("Test loop and type done");
        wired <= 1'b1;
        wr(OFS_CTRL, 32'h0000_0000);
        tick(10);
        h0 = n_home;
        s0 = n_stall;
        pulses(3, 1'b0, 5, 10);
        tick(5);
        check("home low", 32'(n_home - h0), 32'd3);
        check("stall low", 32'(n_stall - s0), 32'd3);
        wr(OFS_CTRL, 32'h0000_0010);
        tick(10);
        h0 = n_home;
        pulses(2, 1'b0, 10, 5);
        tick(5);
        check("home high", 32'(n_home - h0), 32'd2);
        bus(1'b0, OFS_STATUS, 32'h0, 1'b0, r);
        check("high active", {31'h0, r[6]}, 32'h1);
        $display("Test sensor done");
        bus(1'b0, OFS_POSITION, 32'h0, 1'b0, p0);
        tgt = p0 + 32'd20 + 32'($urandom % 20);
        wr(OFS_CTRL, 32'h0000_0002);
        lose_n    <= 8'h05;
        lose_load <= 1'b1;
        tick(1);
        lose_load <= 1'b0;
        s0 = n_step;
        wr(OFS_TARGET, tgt);
        wr(OFS_CTRL, 32'h0000_0022);
        tick(50);
        r = 32'h0;
        for (k = 0; k < 100 && r[4] !== 1'b1; k++) begin
            tick(20);
            bus(1'b0, OFS_STATUS, 32'h0, 1'b0, r);
        end
        check("done", {31'h0, r[4]}, 32'h1);
        check("step dir", {31'h0, dir}, 32'h1);
        bus(1'b0, OFS_POSITION, 32'h0, 1'b0, r);
        check("reached", {31'h0, $signed(r - tgt) <= 4 && $signed(r - tgt) >= -4}, 32'h1);
        check("corrected", {31'h0, n_step - s0 > int'(tgt - p0)}, 32'h1);
        $display("Test mediated done");
        complete_run();
    end
endmodule
`default_nettype wire
